//--- rtl/watchdog_interval_timer.sv
`timescale 1ns/100ps
`include "wdt_params.svh"

// Behaviour
// - 8-bit readable writable counter increments on selected tap while enabled.
// - rollover from all ones to zero sets the overflow flag.
// - counter is zero after reset and held zero while timer disabled.
// - status bits 7..5 clear on reset and standby; bits 2..0 only on reset.
// - software clears the overflow flag only by reading it as one then writing zero.
// - mode bit picks interval interrupt (0) or chip reset (1) on overflow.
// - reserved status bits always read as one and ignore writes.
// - clock select codes pick divide by 2,32,64,128,256,512,2048,4096.
// - of the resets, only external reset clears reset-status bits 7 and 6.
// - watchdog-mode overflow resets the chip and sets the watchdog reset flag.
// - watchdog reset flag clears on external reset or read-one-then-write-zero.
// - reset output enable lets a watchdog-mode overflow drive the reset pin low.
// - counter and control status are written only through word writes.
// - shared write address; upper byte 5a loads counter, a5 loads status.
// - a5/00 word clears watchdog flag; 5a word loads reset output enable.
// - byte reads at three separate addresses return status, counter, reset status.
// - watchdog overflow holds chip internal reset for 518 cycles.
// - enabled reset pin stays asserted 132 cycles after watchdog overflow.
// - counter write in the same cycle as a tick wins and skips increment.
// - internal watchdog reset clears overflow flag but keeps watchdog flag.
module watchdog_interval_timer (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic [`WDT_ADDR_W-1:0] addr_i,
    input wire logic wr_i,
    input wire logic wr_word_i,
    input wire logic [15:0] wdata_i,
    input wire logic rd_i,
    input wire logic standby_i,
    output logic [7:0] rdata_o,
    output logic interval_irq_o,
    output logic chip_rst_o,
    output logic rst_pin_o,
    output logic rst_pin_oe_n_o
);

    // ****************************************
    // helpers
    // ****************************************
    // tap mask: the tick fires when all masked prescaler bits are ones
    function automatic logic [`WDT_PRESC_W-1:0] tap_mask(input logic [2:0] cks);
        logic [`WDT_PRESC_W-1:0] m;
        m = '0;
        case (cks)
            3'h0: m = 12'h001;
            3'h1: m = 12'h01f;
            3'h2: m = 12'h03f;
            3'h3: m = 12'h07f;
            3'h4: m = 12'h0ff;
            3'h5: m = 12'h1ff;
            3'h6: m = 12'h7ff;
            default: m = 12'hfff;
        endcase
        return m;
    endfunction : tap_mask

    function automatic logic word_wr(input logic [`WDT_ADDR_W-1:0] a, input logic [`WDT_ADDR_W-1:0] tgt,
                                     input logic wr, input logic word);
        return wr && word && (a == tgt);
    endfunction : word_wr

    // ****************************************
    // state
    // ****************************************
    localparam wdt_pkg::state_t RESET_STATE = '{
        count: `WDT_CNT_RST,
        ovf: 1'b0,
        mode: 1'b0,
        timer_enable_bit: 1'b0,
        cks: 3'h0,
        watchdog_rst_flag: 1'b0,
        rst_output_enable: 1'b0,
        ovf_armed: 1'b0,
        watchdog_rst_flag_armed: 1'b0,
        presc: '0,
        rst_cnt: '0,
        pin_cnt: '0,
        chip_rst: 1'b0,
        pin_oe_n: 1'b1,
        pin_lvl: 1'b1,
        irq: 1'b0,
        rdata: `WDT_RDATA_NONE
    };

    wdt_pkg::state_t state_r;
    wdt_pkg::state_t state_nxt;

    logic tick;
    logic ovf_evt;
    logic wr_tcs;
    logic wr_rcs;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [`WDT_PRESC_W-1:0] mask;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        hi = wdata_i[15:8];
        lo = wdata_i[7:0];
        // free-running prescaler: a divider change never restarts it, so stop the
        // timer first or the first period after the change is short
        mask = tap_mask(state_r.cks);
        tick = (state_r.presc & mask) == mask;
        state_nxt.presc = state_r.presc + `WDT_PRESC_W'(1);
        // byte writes never match; writes are ignored while the chip sits in reset
        wr_tcs = word_wr(addr_i, `WDT_TCS_WADDR, wr_i, wr_word_i) && !state_r.chip_rst;
        wr_rcs = word_wr(addr_i, `WDT_RCS_WADDR, wr_i, wr_word_i) && !state_r.chip_rst;
        ovf_evt = state_r.timer_enable_bit && tick && (state_r.count == `WDT_CNT_MAX);

        // control/status write; reserved bits have no storage
        if (wr_tcs && hi == `WDT_PWD_CSR) begin
            state_nxt.mode = lo[`WDT_MODE_BIT];
            state_nxt.timer_enable_bit = lo[`WDT_TME_BIT];
            state_nxt.cks = lo[`WDT_CKS_HI:`WDT_CKS_LO];
            if (!lo[`WDT_OVF_BIT] && state_r.ovf_armed) begin
                state_nxt.ovf = 1'b0;
                state_nxt.ovf_armed = 1'b0;
            end
        end

        // counter: a password write beats a tick in the same cycle
        if (wr_tcs && hi == `WDT_PWD_CNT) begin
            state_nxt.count = lo;
        end else if (state_r.timer_enable_bit && tick) begin
            state_nxt.count = state_r.count + 8'h01;
        end
        if (!state_nxt.timer_enable_bit) begin
            state_nxt.count = `WDT_CNT_RST;
        end

        // set beats a clear arriving in the same cycle
        if (ovf_evt) begin
            state_nxt.ovf = 1'b1;
        end

        // reading a set flag arms its clear
        if (rd_i && addr_i == `WDT_TCS_RADDR && state_r.ovf) begin
            state_nxt.ovf_armed = 1'b1;
        end
        if (rd_i && addr_i == `WDT_RCS_RADDR && state_r.watchdog_rst_flag) begin
            state_nxt.watchdog_rst_flag_armed = 1'b1;
        end

        // reset control/status write
        if (wr_rcs && hi == `WDT_PWD_CSR && lo == `WDT_RCS_CLR_DATA && state_r.watchdog_rst_flag_armed) begin
            state_nxt.watchdog_rst_flag = 1'b0;
            state_nxt.watchdog_rst_flag_armed = 1'b0;
        end
        if (wr_rcs && hi == `WDT_PWD_CNT) begin
            state_nxt.rst_output_enable = lo[`WDT_RST_OUTPUT_ENABLE_BIT];
        end

        // reset pulse timers
        if (state_r.rst_cnt != '0) begin
            state_nxt.rst_cnt = state_r.rst_cnt - `WDT_RSTCNT_W'(1);
        end
        if (state_r.pin_cnt != '0) begin
            state_nxt.pin_cnt = state_r.pin_cnt - `WDT_PINCNT_W'(1);
        end
        if (ovf_evt && state_r.mode) begin
            state_nxt.watchdog_rst_flag = 1'b1;
            state_nxt.rst_cnt = `WDT_RSTCNT_W'(`WDT_RST_CYCLES);
            if (state_r.rst_output_enable) begin
                state_nxt.pin_cnt = `WDT_PINCNT_W'(`WDT_PIN_CYCLES);
            end
        end

        // standby keeps the clock select
        if (standby_i) begin
            state_nxt.ovf = 1'b0;
            state_nxt.mode = 1'b0;
            state_nxt.timer_enable_bit = 1'b0;
            state_nxt.count = `WDT_CNT_RST;
            state_nxt.ovf_armed = 1'b0;
        end

        // internal chip reset reaches this block too, except the reset-status bits and the prescaler
        if (state_r.chip_rst) begin
            state_nxt.count = `WDT_CNT_RST;
            state_nxt.ovf = 1'b0;
            state_nxt.mode = 1'b0;
            state_nxt.timer_enable_bit = 1'b0;
            state_nxt.cks = 3'h0;
            state_nxt.ovf_armed = 1'b0;
            state_nxt.watchdog_rst_flag_armed = 1'b0;
        end

        // read data, answered one cycle after the strobe
        state_nxt.rdata = `WDT_RDATA_NONE;
        if (rd_i) begin
            case (addr_i)
                `WDT_TCS_RADDR: begin
                    state_nxt.rdata = {state_r.ovf, state_r.mode, state_r.timer_enable_bit, 2'b00, state_r.cks}
                                      | `WDT_TCS_RSVD;
                end
                `WDT_CNT_RADDR: begin
                    state_nxt.rdata = state_r.count;
                end
                `WDT_RCS_RADDR: begin
                    state_nxt.rdata = {state_r.watchdog_rst_flag, state_r.rst_output_enable, 6'h00} | `WDT_RCS_RSVD;
                end
                default: begin
                    state_nxt.rdata = `WDT_RDATA_NONE;
                end
            endcase
        end

        // outputs, registered
        state_nxt.irq = state_nxt.ovf && !state_nxt.mode;
        state_nxt.chip_rst = state_nxt.rst_cnt != '0;
        state_nxt.pin_oe_n = state_nxt.pin_cnt == '0;
        state_nxt.pin_lvl = state_nxt.pin_oe_n;
    end

    // ****************************************
    // registers
    // ****************************************
    // srst_i is the external reset input: the only reset that clears watchdog_rst_flag and rst_output_enable
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state_r <= RESET_STATE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign rdata_o = state_r.rdata;
    assign interval_irq_o = state_r.irq;
    assign chip_rst_o = state_r.chip_rst;
    assign rst_pin_o = state_r.pin_lvl;
    assign rst_pin_oe_n_o = state_r.pin_oe_n;

endmodule : watchdog_interval_timer

//--- shared/wdt_params.svh
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// ****************************************
// addresses, lower 20 bits
// ****************************************
`define WDT_ADDR_W 20
`define WDT_TCS_WADDR 20'hfff8c
`define WDT_RCS_WADDR 20'hfff8e
`define WDT_TCS_RADDR 20'hfff8c
`define WDT_CNT_RADDR 20'hfff8d
`define WDT_RCS_RADDR 20'hfff8f

// ****************************************
// passwords in the upper byte of a word write; flag clear data in the lower byte
// ****************************************
`define WDT_PWD_CNT 8'h5a
`define WDT_PWD_CSR 8'ha5
`define WDT_RCS_CLR_DATA 8'h00

// ****************************************
// field positions
// ****************************************
`define WDT_OVF_BIT 7
`define WDT_MODE_BIT 6
`define WDT_TME_BIT 5
`define WDT_CKS_HI 2
`define WDT_CKS_LO 0
`define WDT_WATCHDOG_RST_FLAG_BIT 7
`define WDT_RST_OUTPUT_ENABLE_BIT 6

// ****************************************
// reset values and fixed read bits
// ****************************************
`define WDT_TCS_RSVD 8'h18
`define WDT_RCS_RSVD 8'h3f
`define WDT_CNT_RST 8'h00
`define WDT_CNT_MAX 8'hff
`define WDT_RDATA_NONE 8'h00

// ****************************************
// widths and timing
// ****************************************
`define WDT_PRESC_W 12
`define WDT_RSTCNT_W 10
`define WDT_PINCNT_W 8
`define WDT_CYC_PER_STATE 1
`define WDT_RST_STATES 518
`define WDT_PIN_STATES 132
`define WDT_RST_CYCLES (`WDT_RST_STATES * `WDT_CYC_PER_STATE)
`define WDT_PIN_CYCLES (`WDT_PIN_STATES * `WDT_CYC_PER_STATE)

`endif

//--- shared/wdt_pkg.sv
`include "wdt_params.svh"

package wdt_pkg;

    // ****************************************
    // complete block state
    // ****************************************
    typedef struct packed {
        logic [7:0] count;
        logic ovf;
        logic mode;
        logic timer_enable_bit;
        logic [2:0] cks;
        logic watchdog_rst_flag;
        logic rst_output_enable;
        logic ovf_armed;
        logic watchdog_rst_flag_armed;
        logic [`WDT_PRESC_W-1:0] presc;
        logic [`WDT_RSTCNT_W-1:0] rst_cnt;
        logic [`WDT_PINCNT_W-1:0] pin_cnt;
        logic chip_rst;
        logic pin_oe_n;
        logic pin_lvl;
        logic irq;
        logic [7:0] rdata;
    } state_t;

endpackage : wdt_pkg

//--- bench/wdt_checker_properties.sv
`timescale 1ns/100ps
// ****************************************
// port checks
// ****************************************
module wdt_checker (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic standby_i,
    input wire logic [7:0] rdata_o,
    input wire logic interval_irq_o,
    input wire logic chip_rst_o,
    input wire logic rst_pin_o,
    input wire logic rst_pin_oe_n_o
);
    logic [9:0] rcnt_r;
    logic [7:0] pcnt_r;
    // pulse lengths too long for a repetition, so count them
    always_ff @(posedge core_clk_i) begin
        rcnt_r <= (srst_i || !chip_rst_o) ? 10'h000 : rcnt_r + 10'h001;
        pcnt_r <= (srst_i || rst_pin_oe_n_o) ? 8'h00 : pcnt_r + 8'h01;
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    property p_rd_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_rst_len; $fell(chip_rst_o) |-> rcnt_r == 10'd518; endproperty
    a_rst_len: assert property (p_rst_len) else $error("internal reset length");
    property p_pin_len; $rose(rst_pin_oe_n_o) |-> pcnt_r == 8'd132; endproperty
    a_pin_len: assert property (p_pin_len) else $error("pin pulse length");
    property p_pin_low; !rst_pin_oe_n_o |-> !rst_pin_o && chip_rst_o; endproperty
    a_pin_low: assert property (p_pin_low) else $error("pin driven wrongly");
    property p_pin_start; $fell(rst_pin_oe_n_o) |-> $rose(chip_rst_o); endproperty
    a_pin_start: assert property (p_pin_start) else $error("pin start");
    property p_wd_no_irq; $rose(chip_rst_o) |-> !interval_irq_o; endproperty
    a_wd_no_irq: assert property (p_wd_no_irq) else $error("irq in watchdog mode");
    property p_after_rst; $past(srst_i) |-> !chip_rst_o && rst_pin_oe_n_o && !interval_irq_o; endproperty
    a_after_rst: assert property (p_after_rst) else $error("outputs after reset");
    property p_irq_hold; interval_irq_o && !wr_i && !standby_i |=> interval_irq_o; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
endmodule : wdt_checker

bind watchdog_interval_timer wdt_checker u_chk (.core_clk_i(core_clk_i), .srst_i(srst_i), .wr_i(wr_i),
    .rd_i(rd_i), .standby_i(standby_i), .rdata_o(rdata_o), .interval_irq_o(interval_irq_o),
    .chip_rst_o(chip_rst_o), .rst_pin_o(rst_pin_o), .rst_pin_oe_n_o(rst_pin_oe_n_o));

//--- bench/watchdog_interval_timer_bench.sv
`timescale 1ns/100ps
module watchdog_interval_timer_bench;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [19:0] addr_i = 20'h00000;
    logic wr_i = 1'b0;
    logic wr_word_i = 1'b0;
    logic [15:0] wdata_i = 16'h0000;
    logic rd_i = 1'b0;
    logic standby_i = 1'b0;
    logic [7:0] rdata_o;
    logic interval_irq_o, chip_rst_o, rst_pin_o, rst_pin_oe_n_o;
    int bad_count = 0;
    int comparisons = 0;
    int n;
    localparam int divs[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
    watchdog_interval_timer uut (.core_clk_i(core_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wr_i(wr_i),
        .wr_word_i(wr_word_i), .wdata_i(wdata_i), .rd_i(rd_i), .standby_i(standby_i), .rdata_o(rdata_o),
        .interval_irq_o(interval_irq_o), .chip_rst_o(chip_rst_o), .rst_pin_o(rst_pin_o),
        .rst_pin_oe_n_o(rst_pin_oe_n_o));
    initial begin
        forever #10 core_clk_i = ~core_clk_i;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        comparisons++;
        if (^got === 1'bx || got < lo || got > hi) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h..%h", $time, got, lo, hi);
        end
    endtask : chk
    task automatic wr(input logic [19:0] a, input logic [15:0] d, input logic w);
        @(posedge core_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_word_i <= w;
        wr_i <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [19:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge core_clk_i);
        rd_i <= 1'b0;
        #1 chk({8'h00, rdata_o}, {8'h00, e}, {8'h00, e});
    endtask : rd
    task automatic wait_rst(input logic v, input int lim);
        n = 0;
        while (chip_rst_o !== v && n < lim) begin
            @(posedge core_clk_i);
            #1 n++;
        end
    endtask : wait_rst
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs;
        rd(20'hfff8c, 8'h18);
        rd(20'hfff8d, 8'h00);
        rd(20'hfff8f, 8'h3f);
        rd(20'hfff8e, 8'h00);
        wr(20'hfff8c, 16'h5a77, 1'b1);
        rd(20'hfff8d, 8'h00);
        wr(20'hfff8c, 16'ha520, 1'b0);
        rd(20'hfff8c, 8'h18);
        wr(20'hfff8c, 16'h1120, 1'b1);
        rd(20'hfff8c, 8'h18);
        wr(20'hfff8c, 16'ha5ff, 1'b1);
        rd(20'hfff8c, 8'h7f);
        wr(20'hfff8c, 16'h5afe, 1'b1);
        rd(20'hfff8d, 8'hfe);
        wr(20'hfff8c, 16'ha500, 1'b1);
        rd(20'hfff8d, 8'h00);
        $display("test registers done");
    endtask : t_regs
    task automatic t_cks;
        // the prescaler runs free, so one tick of slack either way
        for (int c = 0; c < 8; c++) begin
            wr(20'hfff8c, {8'ha5, 5'b00100, 3'(c)}, 1'b1);
            wr(20'hfff8c, 16'h5a00, 1'b1);
            repeat (4 * divs[c]) @(posedge core_clk_i);
            @(posedge core_clk_i);
            addr_i <= 20'hfff8d;
            rd_i <= 1'b1;
            @(posedge core_clk_i);
            rd_i <= 1'b0;
            #1 chk({8'h00, rdata_o}, 16'd3, 16'd5);
        end
        wr(20'hfff8c, 16'ha500, 1'b1);
        $display("test clock select done");
    endtask : t_cks
    task automatic t_interval;
        wr(20'hfff8c, 16'ha520, 1'b1);
        wr(20'hfff8c, 16'h5af0, 1'b1);
        n = 0;
        while (interval_irq_o !== 1'b1 && n < 100) begin
            @(posedge core_clk_i);
            #1 n++;
        end
        chk({14'h0000, interval_irq_o, chip_rst_o}, 16'h2, 16'h2);
        wr(20'hfff8c, 16'ha520, 1'b1);
        chk({15'h0000, interval_irq_o}, 16'h1, 16'h1);
        rd(20'hfff8c, 8'hb8);
        wr(20'hfff8c, 16'ha5a0, 1'b1);
        chk({15'h0000, interval_irq_o}, 16'h1, 16'h1);
        wr(20'hfff8c, 16'ha520, 1'b1);
        chk({15'h0000, interval_irq_o}, 16'h0, 16'h0);
        // timer stopped before standby, as software must; standby still clears the mode bit
        wr(20'hfff8c, 16'ha547, 1'b1);
        rd(20'hfff8c, 8'h5f);
        @(posedge core_clk_i);
        standby_i <= 1'b1;
        @(posedge core_clk_i);
        standby_i <= 1'b0;
        rd(20'hfff8c, 8'h1f);
        $display("test interval done");
    endtask : t_interval
    task automatic t_watchdog;
        wr(20'hfff8e, 16'h5a40, 1'b1);
        rd(20'hfff8f, 8'h7f);
        wr(20'hfff8c, 16'ha560, 1'b1);
        wr(20'hfff8c, 16'h5af8, 1'b1);
        wait_rst(1'b1, 100);
        chk({12'h000, chip_rst_o, interval_irq_o, rst_pin_oe_n_o, rst_pin_o}, 16'h8, 16'h8);
        wait_rst(1'b0, 600);
        chk(16'(n), 16'd518, 16'd518);
        rd(20'hfff8f, 8'hff);
        rd(20'hfff8c, 8'h18);
        wr(20'hfff8e, 16'ha500, 1'b1);
        rd(20'hfff8f, 8'h7f);
        @(posedge core_clk_i);
        srst_i <= 1'b1;
        @(posedge core_clk_i);
        srst_i <= 1'b0;
        rd(20'hfff8f, 8'h3f);
        // overflow with the pin disabled: internal reset only, pin stays released
        wr(20'hfff8c, 16'ha560, 1'b1);
        wr(20'hfff8c, 16'h5af8, 1'b1);
        wait_rst(1'b1, 100);
        chk({12'h000, chip_rst_o, interval_irq_o, rst_pin_oe_n_o, rst_pin_o}, 16'hb, 16'hb);
        wait_rst(1'b0, 600);
        chk(16'(n), 16'd518, 16'd518);
        rd(20'hfff8f, 8'hbf);
        $display("test watchdog done");
    endtask : t_watchdog
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (2) @(posedge core_clk_i);
        srst_i <= 1'b0;
        t_regs();
        t_cks();
        t_interval();
        t_watchdog();
        wrap_up();
    end
    initial begin
        #1500000;
        bad_count++;
        wrap_up();
    end
endmodule : watchdog_interval_timer_bench
